/* common/ffsig_defines.svh */
// constants for far-end fault signalling
`ifndef FFSIG_DEFINES_SVH
`define FFSIG_DEFINES_SVH
`define FFSIG_ONES_LEN      7'h54
`define FFSIG_PAT_LEN       7'h55
`define FFSIG_DET_NEEDED    2'h3
`define FFSIG_CNT_RESET     7'h00
`define FFSIG_HITS_RESET    2'h0
`define FFSIG_STATUS_RESET  1'b0
`endif

/* common/ffsig_pkg.sv */
// types for far-end fault signalling
package ffsig_pkg;
  typedef enum logic [1:0] {
    FFSIG_TX_PASS,
    FFSIG_TX_FAULT
  } ffsig_tx_state_e;

  typedef struct packed {
    logic valid;
    logic data;
  } ffsig_bit_s;

  typedef logic [6:0] ffsig_cnt_t;
endpackage

/* verilog/ffsig_sync.sv */
// two-stage synchroniser for pin levels
`timescale 1ns/10ps
module ffsig_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

/* verilog/ffsig_top.sv */
// far-end fault detection and generation on the fiber line stream
`timescale 1ns/10ps
`include "ffsig_defines.svh"
module ffsig_top
  import ffsig_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       soft_reset,
  input  wire logic       fiber_100m_mode,
  input  wire logic       link_ok,
  input  wire ffsig_bit_s rx_bit,
  input  wire ffsig_bit_s tx_in_bit,
  output ffsig_bit_s      tx_out_bit,
  output logic            remote_fault,
  output logic            far_end_fault_signal,
  output logic            scramble_bypass
);
  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic [1:0] pins_sync;

  ffsig_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({fiber_100m_mode, link_ok}),
    .q        (pins_sync)
  );

  wire logic fiber_on = pins_sync[1];
  wire logic link_up  = pins_sync[0];
  wire logic clr      = soft_reset | ~fiber_on;

  // ----------------------------------------
  // receive pattern detector
  // ----------------------------------------
  ffsig_cnt_t ones_cnt;
  logic [1:0] hits;
  ffsig_cnt_t next_ones_cnt;
  logic [1:0] next_hits;

  wire logic ones_full = ones_cnt >= `FFSIG_ONES_LEN;
  wire logic rx_one    = rx_bit.valid & rx_bit.data;
  wire logic rx_zero   = rx_bit.valid & ~rx_bit.data;
  wire logic pat_done  = rx_zero & (ones_cnt == `FFSIG_ONES_LEN);
  wire logic pat_break = rx_zero & ~pat_done;
  wire logic reach3    = pat_done & (hits == (`FFSIG_DET_NEEDED - 2'h1));

  always_comb begin
    next_ones_cnt = ones_cnt;
    next_hits     = hits;
    if (rx_one && !ones_full) begin
      next_ones_cnt = ones_cnt + 7'h01;
    end else if (rx_one) begin
      next_ones_cnt = `FFSIG_ONES_LEN + 7'h01;
    end
    if (rx_zero) begin
      next_ones_cnt = `FFSIG_CNT_RESET;
    end
    if (pat_done && hits != `FFSIG_DET_NEEDED) begin
      next_hits = hits + 2'h1;
    end else if (pat_break) begin
      next_hits = `FFSIG_HITS_RESET;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ones_cnt     <= `FFSIG_CNT_RESET;
      hits         <= `FFSIG_HITS_RESET;
      remote_fault <= `FFSIG_STATUS_RESET;
    end else if (clr) begin
      ones_cnt     <= `FFSIG_CNT_RESET;
      hits         <= `FFSIG_HITS_RESET;
      remote_fault <= `FFSIG_STATUS_RESET;
    end else begin
      ones_cnt     <= next_ones_cnt;
      hits         <= next_hits;
      remote_fault <= remote_fault | reach3;
    end
  end

  // ----------------------------------------
  // transmit pattern generator
  // ----------------------------------------
  ffsig_tx_state_e tx_state;
  ffsig_tx_state_e next_tx_state;
  ffsig_cnt_t      gen_cnt;
  ffsig_cnt_t      next_gen_cnt;

  wire logic fault_req = fiber_on & ~link_up & ~soft_reset;
  wire logic gen_last  = gen_cnt == (`FFSIG_PAT_LEN - 7'h01);
  wire logic gen_bit   = ~gen_last;
  wire logic in_fault  = tx_state == FFSIG_TX_FAULT;

  always_comb begin
    next_tx_state = tx_state;
    next_gen_cnt  = gen_cnt;
    unique case (tx_state)
      FFSIG_TX_PASS: begin
        if (fault_req) begin
          next_tx_state = FFSIG_TX_FAULT;
          next_gen_cnt  = `FFSIG_CNT_RESET;
        end
      end
      FFSIG_TX_FAULT: begin
        if (tx_in_bit.valid) begin
          next_gen_cnt = gen_last ? `FFSIG_CNT_RESET : gen_cnt + 7'h01;
          if (gen_last && !fault_req) begin
            next_tx_state = FFSIG_TX_PASS;
          end
        end
        if (!fiber_on || soft_reset) begin
          next_tx_state = FFSIG_TX_PASS;
        end
      end
      default: begin
        next_tx_state = FFSIG_TX_PASS;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_state             <= FFSIG_TX_PASS;
      gen_cnt              <= `FFSIG_CNT_RESET;
      tx_out_bit           <= '0;
      far_end_fault_signal <= 1'b0;
      scramble_bypass      <= 1'b0;
    end else begin
      tx_state             <= next_tx_state;
      gen_cnt              <= next_gen_cnt;
      tx_out_bit.valid     <= tx_in_bit.valid;
      tx_out_bit.data      <= in_fault ? gen_bit : tx_in_bit.data;
      far_end_fault_signal <= in_fault;
      scramble_bypass      <= fiber_on;
    end
  end
endmodule

/* sim/ffsig_assertions.sv */
// fault signalling checker
`timescale 1ns/10ps
module ffsig_chk import ffsig_pkg::*; (
  input wire logic       core_clk, rst, soft_reset, fiber_100m_mode, link_ok,
  input wire ffsig_bit_s rx_bit, tx_in_bit, tx_out_bit,
  input wire logic       remote_fault, far_end_fault_signal, scramble_bypass
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_rf_cause: assert property ($rose(remote_fault) |-> $past(rx_bit) == 2'h2) else $error("rf rise");
  chk_soft_clr: assert property (soft_reset |=> !remote_fault) else $error("rf kept");
  chk_off_rf: assert property (!fiber_100m_mode [*5] |=> !remote_fault) else $error("rf off");
  chk_off_tx: assert property (!fiber_100m_mode [*5] |=> !far_end_fault_signal) else $error("sent off");
  chk_bypass_on: assert property (fiber_100m_mode [*5] |=> scramble_bypass) else $error("no bypass");
  chk_tx_delay: assert property (tx_out_bit.valid == $past(tx_in_bit.valid)) else $error("late");
  chk_off_pass: assert property (!fiber_100m_mode [*5] |=> tx_out_bit == $past(tx_in_bit)) else $error("alt");
  chk_fault_go: assert property ((fiber_100m_mode && !link_ok) [*6] |-> far_end_fault_signal) else $error("no");
  cover property ($rose(remote_fault));
  cover property ($rose(far_end_fault_signal));
  cover property ($fell(far_end_fault_signal));
endmodule
bind ffsig_top ffsig_chk chk_u (.*);

/* sim/ffsig_remote.sv */
// remote station and fiber link model
`timescale 1ns/10ps
module ffsig_remote import ffsig_pkg::*; (
  input  wire logic       core_clk,
  input  wire ffsig_cnt_t ones,
  input  wire logic       go,
  input  wire ffsig_bit_s tx_out_bit,
  output ffsig_bit_s      rx_bit,
  output int              seen
);
  int n, run;
  initial rx_bit = 2'h0;
  always @(posedge core_clk) begin
    rx_bit <= {go, go ? n < ones : ~rx_bit.data};
    n <= go && n < ones ? n + 1 : 0;
    if (tx_out_bit.valid) run <= tx_out_bit.data ? run + 1 : 0;
    if (tx_out_bit === 2'h2 && run == 84) seen <= seen + 1;
  end
endmodule

/* sim/ffsig_bench.sv */
// bench for fault signalling
`timescale 1ns/10ps
module ffsig_bench import ffsig_pkg::*;;
  logic core_clk = 0, rst = 1, soft_reset = 0, fiber_100m_mode = 1, link_ok = 1, go = 0;
  logic remote_fault, far_end_fault_signal, scramble_bypass;
  ffsig_cnt_t ones = 7'h54;
  ffsig_bit_s rx_bit, tx_out_bit, tx_in_bit = 2'h0;
  int seen, mismatches, compares, i;
  always #12.5 core_clk = ~core_clk;
  ffsig_top dut_u (
    .core_clk             (core_clk),
    .rst                  (rst),
    .soft_reset           (soft_reset),
    .fiber_100m_mode      (fiber_100m_mode),
    .link_ok              (link_ok),
    .rx_bit               (rx_bit),
    .tx_in_bit            (tx_in_bit),
    .tx_out_bit           (tx_out_bit),
    .remote_fault         (remote_fault),
    .far_end_fault_signal (far_end_fault_signal),
    .scramble_bypass      (scramble_bypass)
  );
  ffsig_remote far_u (
    .core_clk   (core_clk),
    .ones       (ones),
    .go         (go),
    .tx_out_bit (tx_out_bit),
    .rx_bit     (rx_bit),
    .seen       (seen)
  );
  task chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t check %0d failed", $time, compares);
    end
  endtask
  task send(input ffsig_cnt_t o);
    ones = o;
    go = 1;
    repeat (3 * (o + 1)) @(negedge core_clk);
    go = 0;
    repeat (2) @(negedge core_clk);
  endtask
  task detect;
    send(7'h55);
    chk(remote_fault === 1'b0);
    send(7'h20);
    chk(remote_fault === 1'b0);
    send(7'h54);
    chk(remote_fault === 1'b1);
    soft_reset = 1;
    @(negedge core_clk);
    soft_reset = 0;
    @(negedge core_clk);
    chk(remote_fault === 1'b0);
  endtask
  task gen_off;
    link_ok = 0;
    for (i = 0; i < 400 && seen < 2; i++) @(negedge core_clk);
    chk(seen >= 2 && far_end_fault_signal === 1'b1 && scramble_bypass === 1'b1);
    link_ok = 1;
    for (i = 0; i < 100 && far_end_fault_signal !== 1'b0; i++) @(negedge core_clk);
    chk(far_end_fault_signal === 1'b0);
    repeat (2) @(negedge core_clk);
    chk(tx_out_bit === 2'h2);
    link_ok = 0;
    repeat (8) @(negedge core_clk);
    chk(far_end_fault_signal === 1'b1);
    fiber_100m_mode = 0;
    repeat (8) @(negedge core_clk);
    chk(far_end_fault_signal === 1'b0 && tx_out_bit === 2'h2);
    send(7'h54);
    chk(remote_fault === 1'b0 && scramble_bypass === 1'b0);
  endtask
  task conclude;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 0;
    tx_in_bit = 2'h2;
    detect;
    gen_off;
    conclude;
  end
endmodule
